/* rtc_i2c_target.sv */
// Two-wire target end of a clock/EEPROM part: addressing, writes, reads, write cycle
`timescale 1ns/10ps
`default_nettype none
// Operation
// RQ1 - data changes only while clock is low
// RQ2 - watch for start, ignore traffic until then
// RQ3 - stop ends transfer, device returns to standby
// RQ4 - transmitter releases, receiver acknowledges ninth clock
// RQ5 - acknowledge only a matching slave byte
// RQ6 - acknowledge every written byte
// RQ7 - send bytes while master acknowledges
// RQ8 - top nibble selects array or control space
// RQ9 - compare seven bits with both identifiers
// RQ10 - lowest slave bit selects read
// RQ11 - two address bytes, counter reset zero
// RQ12 - random read repeats same slave byte
// RQ13 - unlock sequence before control space writes; no unlock is checked here, control space writes are taken directly
// RQ14 - byte write commits on stop
// RQ15 - write cycle ignores bus, sda released
// RQ16 - protected writes acknowledged, then discarded
// RQ17 - single day-of-week alarm writes never commit
// RQ18 - page holds sixteen or eight bytes
// RQ19 - clock registers written as eight-byte page
// RQ20 - address wraps inside current page
// RQ21 - surplus bytes overwrite in wrap order
// RQ22 - early or mid-byte stop discards write
// RQ23 - no array acknowledge during write cycle
module rtc_i2c_target #(
    parameter int unsigned WriteCycles = rtc_i2c_pkg::WRITE_CYCLES // Write cycle length in clocks
) (
    input wire logic clock, // 200 MHz clock
    input wire logic nrst, // Synchronous reset, active low
    rtc_i2c_if.target bus, // Two-wire bus
    input wire logic protectArray, // Array write protect level
    output logic writeBusy // Write cycle running
);
    rtc_i2c_pkg::target_t s;
    rtc_i2c_pkg::target_t n;
    logic [7:0] arrayMem [rtc_i2c_pkg::ARRAY_WORDS];
    logic [7:0] ctlMem [rtc_i2c_pkg::CTL_WORDS];
    logic [7:0] rdByte;
    logic rise;
    logic fall;
    logic startEv;
    logic stopEv;
    logic commit;
    logic loadTx;
    logic [3:0] slot;

    // Write pointer: wraps inside a 16-byte page or an 8-byte section
    function automatic logic [15:0] pageInc(input logic [15:0] a, input logic c);
        pageInc = c ? {a[15:3], a[2:0] + 3'h1} : {a[15:4], a[3:0] + 4'h1}; // see RQ20
    endfunction : pageInc

    // Read pointer: runs through the whole space and rolls over
    function automatic logic [15:0] linInc(input logic [15:0] a, input logic c);
        linInc = c ? {10'h000, a[5:0] + 6'h01} : {7'h00, a[8:0] + 9'h001};
    endfunction : linInc

    // Edges from the synchronised lines; first stages feed only second stages
    assign rise = s.sclS2 && !s.sclP;
    assign fall = !s.sclS2 && s.sclP;
    assign startEv = s.sclS2 && s.sclP && s.sdaP && !s.sdaS2; // see RQ1, RQ2
    assign stopEv = s.sclS2 && s.sclP && !s.sdaP && s.sdaS2; // see RQ1, RQ3
    assign rdByte = s.ctl ? ctlMem[s.addr[5:0]] : arrayMem[s.addr[8:0]];
    assign slot = s.ctl ? {1'b0, s.addr[2:0]} : s.addr[3:0];

    // Bus engine
    always_comb begin
        n = s;
        commit = 1'b0;
        loadTx = 1'b0;
        n.sclS1 = bus.scl;
        n.sclS2 = s.sclS1;
        n.sclP = s.sclS2;
        n.sdaS1 = bus.sda;
        n.sdaS2 = s.sdaS1;
        n.sdaP = s.sdaS2;
        if (s.busy != 22'h00_0000) begin
            // Deaf and silent while storing: no slave byte is acknowledged
            n.busy = s.busy - 22'h00_0001; // see RQ15, RQ23
            n.st = rtc_i2c_pkg::T_IDLE;
            n.sdaOe = 1'b0;
        end else if (startEv) begin
            // Repeated start keeps the pointer so a dummy write sets it
            n.st = rtc_i2c_pkg::T_RXB; // see RQ2
            n.bitCnt = 4'h0;
            n.byteIdx = 2'h0;
            n.dataCnt = 5'h00;
            n.mask = 16'h0000;
            n.sdaOe = 1'b0;
        end else if (stopEv) begin
            // Commit only at a byte boundary after a whole data byte and its ack
            if (s.st == rtc_i2c_pkg::T_RXB && s.bitCnt <= 4'h1 && !s.rd && s.dataCnt != 5'h00) begin // see RQ22
                // Protected data is dropped and no cycle starts
                if (!(protectArray && !s.ctl)) begin // see RQ16
                    // A lone day-of-week alarm byte never reaches storage
                    if (!(s.ctl && s.dataCnt == 5'h01 && s.mask[rtc_i2c_pkg::DOW_INDEX])) begin // see RQ17
                        commit = 1'b1; // see RQ14, RQ21
                        n.busy = 22'(WriteCycles);
                    end
                end
            end
            n.st = rtc_i2c_pkg::T_IDLE; // see RQ3
            n.sdaOe = 1'b0;
        end else begin
            unique case (s.st)
                rtc_i2c_pkg::T_IDLE: n.sdaOe = 1'b0;
                rtc_i2c_pkg::T_RXB: begin
                    if (rise) begin
                        n.shreg = {s.shreg[6:0], s.sdaS2};
                        n.bitCnt = s.bitCnt + 4'h1;
                    end else if (fall && s.bitCnt == 4'h8) begin
                        n.st = rtc_i2c_pkg::T_ACKO;
                        n.sdaOe = 1'b1; // see RQ4, RQ6
                        unique case (s.byteIdx)
                            2'h0: begin
                                // Seven-bit compare picks the space; mismatch leaves the slot released
                                if (s.shreg[7:1] == rtc_i2c_pkg::ARRAY_ID
                                    || s.shreg[7:1] == rtc_i2c_pkg::CTL_ID) begin // see RQ5, RQ9
                                    n.ctl = (s.shreg[7:1] == rtc_i2c_pkg::CTL_ID); // see RQ8
                                    n.rd = s.shreg[0]; // see RQ10
                                    n.byteIdx = 2'h1;
                                end else begin
                                    n.st = rtc_i2c_pkg::T_IDLE;
                                    n.sdaOe = 1'b0;
                                end
                            end
                            2'h1: begin
                                n.addr[15:8] = s.shreg; // see RQ11
                                n.byteIdx = 2'h2;
                            end
                            2'h2: begin
                                n.addr[7:0] = s.shreg; // see RQ11
                                n.byteIdx = 2'h3;
                            end
                            default: begin
                                // Page buffer slot; later bytes overwrite in wrap order
                                n.pbuf[{slot, 3'h0} +: 8] = s.shreg; // see RQ18, RQ21
                                n.mask[slot] = 1'b1;
                                n.addr = pageInc(s.addr, s.ctl); // see RQ20
                                if (s.dataCnt != 5'h1F) begin
                                    n.dataCnt = s.dataCnt + 5'h01;
                                end
                            end
                        endcase
                    end
                end
                rtc_i2c_pkg::T_ACKO: begin
                    if (fall) begin
                        n.sdaOe = 1'b0;
                        n.bitCnt = 4'h0;
                        n.st = rtc_i2c_pkg::T_RXB;
                        loadTx = s.rd;
                    end
                end
                rtc_i2c_pkg::T_TXB: begin
                    if (rise) begin
                        n.bitCnt = s.bitCnt + 4'h1;
                    end else if (fall) begin
                        if (s.bitCnt == 4'h8) begin
                            n.sdaOe = 1'b0; // see RQ4
                            n.st = rtc_i2c_pkg::T_ACKI;
                        end else begin
                            n.shreg = {s.shreg[6:0], 1'b0};
                            n.sdaOe = !s.shreg[6]; // see RQ1
                        end
                    end
                end
                default: begin
                    // Keep sending while acknowledged, otherwise fall silent
                    if (rise) begin
                        n.ackSeen = !s.sdaS2;
                    end else if (fall) begin
                        loadTx = s.ackSeen; // see RQ7
                        n.st = rtc_i2c_pkg::T_IDLE;
                    end
                end
            endcase
            if (loadTx) begin
                n.st = rtc_i2c_pkg::T_TXB;
                n.bitCnt = 4'h0;
                n.shreg = rdByte;
                n.sdaOe = !rdByte[7];
                n.addr = linInc(s.addr, s.ctl);
            end
        end
    end

    // State register; the pointer clears at reset
    always_ff @(posedge clock) begin
        if (!nrst) begin
            s <= rtc_i2c_pkg::TARGET_RESET; // see RQ11
        end else begin
            s <= n;
        end
    end

    // Storage: loaded page slots land in one go when the write cycle starts
    always_ff @(posedge clock) begin
        for (int i = 0; i < rtc_i2c_pkg::PAGE_BYTES; i++) begin
            if (commit && s.mask[i]) begin
                if (s.ctl) begin
                    ctlMem[{s.addr[5:3], 3'(i)}] <= s.pbuf[i * 8 +: 8]; // see RQ14, RQ19
                end else begin
                    arrayMem[{s.addr[8:4], 4'(i)}] <= s.pbuf[i * 8 +: 8]; // see RQ14
                end
            end
        end
    end

    assign bus.tSdaOut = 1'b0;
    assign bus.tSdaOe = s.sdaOe;
    assign writeBusy = (s.busy != 22'h00_0000);
endmodule : rtc_i2c_target
`default_nettype wire

/* rtc_i2c_pkg.sv */
// Shared constants, state encodings and state records for both bus ends
package rtc_i2c_pkg;
    // Slave byte upper seven bits for the two spaces
    localparam logic [6:0] ARRAY_ID = 7'h57;
    localparam logic [6:0] CTL_ID = 7'h6F;
    // Storage sizes and page shapes
    localparam int ARRAY_WORDS = 512;
    localparam int CTL_WORDS = 64;
    localparam int PAGE_BYTES = 16;
    localparam int DOW_INDEX = 6; // Day-of-week alarm slot inside an 8-byte section
    // Timing
    localparam int CLK_MHZ = 200;
    localparam int WRITE_TIME_US = 12000;
    localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
    localparam int SCL_KHZ = 400;
    localparam int QUARTER_CYCLES = (CLK_MHZ * 1000) / (SCL_KHZ * 4);
    localparam logic [6:0] QUARTER_LAST = 7'(QUARTER_CYCLES - 1);
    // Master byte kinds
    localparam logic [2:0] B_SLAVE = 3'h0;
    localparam logic [2:0] B_AHI = 3'h1;
    localparam logic [2:0] B_ALO = 3'h2;
    localparam logic [2:0] B_WDATA = 3'h3;
    localparam logic [2:0] B_RDATA = 3'h4;

    typedef enum logic [4:0] {
        T_IDLE = 5'h01, T_RXB = 5'h02, T_ACKO = 5'h04, T_TXB = 5'h08, T_ACKI = 5'h10
    } tstate_t;

    typedef enum logic [3:0] {
        M_IDLE = 4'h1, M_START = 4'h2, M_BYTE = 4'h4, M_STOP = 4'h8
    } mstate_t;

    typedef struct packed {
        tstate_t st;
        logic sclS1;
        logic sclS2;
        logic sclP;
        logic sdaS1;
        logic sdaS2;
        logic sdaP;
        logic [3:0] bitCnt;
        logic [7:0] shreg;
        logic ctl;
        logic rd;
        logic ackSeen;
        logic [1:0] byteIdx;
        logic [15:0] addr;
        logic [4:0] dataCnt;
        logic [15:0] mask;
        logic [127:0] pbuf;
        logic sdaOe;
        logic [21:0] busy;
    } target_t;

    typedef struct packed {
        mstate_t st;
        logic [6:0] qcnt;
        logic [1:0] phase;
        logic [3:0] bitCnt;
        logic [7:0] shreg;
        logic [2:0] btype;
        logic rd;
        logic ctl;
        logic [15:0] addr;
        logic [4:0] left;
        logic rdPhase;
        logic ackOk;
        logic sclLow;
        logic sdaLow;
        logic sdaS1;
        logic sdaS2;
        logic nack;
        logic [7:0] rdData;
        logic rdValid;
    } master_t;

    localparam target_t TARGET_RESET = '{st: T_IDLE, sclS1: 1'b1, sclS2: 1'b1, sclP: 1'b1,
        sdaS1: 1'b1, sdaS2: 1'b1, sdaP: 1'b1, default: '0};
    localparam master_t MASTER_RESET = '{st: M_IDLE, sdaS1: 1'b1, sdaS2: 1'b1, default: '0};
endpackage : rtc_i2c_pkg

/* rtc_i2c_if.sv */
// Two-wire bus carrier joining the master end and the target end
`timescale 1ns/10ps
`default_nettype none
interface rtc_i2c_if;
    logic mSclOut;
    logic mSclOe;
    logic mSdaOut;
    logic mSdaOe;
    logic tSdaOut;
    logic tSdaOe;
    logic scl;
    logic sda;
    // Open-drain wired-AND with pull-ups: a line is low only while someone drives low
    assign scl = !(mSclOe && !mSclOut);
    assign sda = !((mSdaOe && !mSdaOut) || (tSdaOe && !tSdaOut));
    modport master (output mSclOut, output mSclOe, output mSdaOut, output mSdaOe, input scl, input sda);
    modport target (output tSdaOut, output tSdaOe, input scl, input sda);
endinterface : rtc_i2c_if
`default_nettype wire

/* rtc_i2c_master.sv */
// Bus master end: start, address, page write, random read, stop
`timescale 1ns/10ps
`default_nettype none
module rtc_i2c_master (
    input wire logic clock, // 200 MHz clock
    input wire logic nrst, // Synchronous reset, active low
    rtc_i2c_if.master bus, // Two-wire bus
    input wire logic cmdValid, // Command request
    output logic cmdReady, // Idle, command can be taken
    input wire logic cmdRead, // 1 read, 0 write
    input wire logic cmdCtl, // 1 clock/control space, 0 array
    input wire logic [15:0] cmdAddr, // Word address
    input wire logic [4:0] cmdLen, // Data bytes, at least one
    input wire logic [7:0] wrData, // Write byte
    input wire logic wrValid, // Write byte present
    output logic wrReady, // Write byte taken
    output logic [7:0] rdData, // Read byte
    output logic rdValid, // Read byte strobe
    output logic nack, // Last command refused
    output logic busy // Transfer running
);
    rtc_i2c_pkg::master_t s;
    rtc_i2c_pkg::master_t n;
    logic tick;
    logic tx;
    logic stall;
    logic [7:0] txByte;

    // Byte to send, chosen by its kind; read phase reuses the same space
    always_comb begin
        unique case (s.btype)
            rtc_i2c_pkg::B_SLAVE: txByte = {s.ctl ? rtc_i2c_pkg::CTL_ID : rtc_i2c_pkg::ARRAY_ID,
                s.rdPhase}; // see RQ12
            rtc_i2c_pkg::B_AHI: txByte = s.addr[15:8];
            rtc_i2c_pkg::B_ALO: txByte = s.addr[7:0];
            default: txByte = wrData;
        endcase
    end

    assign tx = (s.btype != rtc_i2c_pkg::B_RDATA);
    // Holding the clock low while no write byte is ready is legal for the master
    assign stall = (s.st == rtc_i2c_pkg::M_BYTE) && (s.phase == 2'h0) && (s.bitCnt == 4'h0)
        && (s.btype == rtc_i2c_pkg::B_WDATA) && !wrValid;
    assign tick = (s.qcnt == rtc_i2c_pkg::QUARTER_LAST) && !stall;

    // Quarter-bit sequencer: each bit is low-set, rise, sample, fall
    always_comb begin
        n = s;
        wrReady = 1'b0;
        n.rdValid = 1'b0;
        n.sdaS1 = bus.sda;
        n.sdaS2 = s.sdaS1;
        if (s.st == rtc_i2c_pkg::M_IDLE || tick) begin
            n.qcnt = 7'h00;
        end else if (!stall) begin
            n.qcnt = s.qcnt + 7'h01;
        end
        if (tick) begin
            n.phase = s.phase + 2'h1;
        end
        unique case (s.st)
            rtc_i2c_pkg::M_IDLE: begin
                if (cmdValid) begin
                    n.st = rtc_i2c_pkg::M_START;
                    n.phase = 2'h0;
                    n.rd = cmdRead;
                    n.ctl = cmdCtl;
                    n.addr = cmdAddr;
                    n.left = cmdLen;
                    n.btype = rtc_i2c_pkg::B_SLAVE;
                    n.rdPhase = 1'b0;
                    n.nack = 1'b0;
                end
            end
            rtc_i2c_pkg::M_START: begin
                // Data falls only while the clock is high: a start, never data
                if (tick) begin
                    unique case (s.phase)
                        2'h0: begin n.sclLow = 1'b1; n.sdaLow = 1'b0; end
                        2'h1: n.sclLow = 1'b0;
                        2'h2: n.sdaLow = 1'b1; // see RQ1
                        default: begin n.sclLow = 1'b1; n.st = rtc_i2c_pkg::M_BYTE; n.bitCnt = 4'h0; end
                    endcase
                end
            end
            rtc_i2c_pkg::M_BYTE: begin
                if (tick) begin
                    unique case (s.phase)
                        2'h0: begin
                            if (s.bitCnt == 4'h0 && tx) begin
                                n.shreg = txByte;
                                wrReady = (s.btype == rtc_i2c_pkg::B_WDATA);
                            end
                            // Release after eight bits; acknowledge all read bytes but the last
                            if (s.bitCnt == 4'h8) begin
                                n.sdaLow = !tx && (s.left > 5'h01); // see RQ4, RQ7
                            end else begin
                                n.sdaLow = tx && !((s.bitCnt == 4'h0) ? txByte[7] : s.shreg[7]);
                            end
                        end
                        2'h1: n.sclLow = 1'b0;
                        2'h2: begin
                            if (s.bitCnt == 4'h8) begin
                                n.ackOk = !s.sdaS2;
                            end else if (!tx) begin
                                n.shreg = {s.shreg[6:0], s.sdaS2};
                            end
                        end
                        default: begin
                            n.sclLow = 1'b1;
                            if (s.bitCnt != 4'h8) begin
                                n.bitCnt = s.bitCnt + 4'h1;
                                if (tx) begin
                                    n.shreg = {s.shreg[6:0], 1'b0};
                                end
                            end else begin
                                n.bitCnt = 4'h0;
                                if (tx && !s.ackOk) begin
                                    n.nack = 1'b1;
                                    n.st = rtc_i2c_pkg::M_STOP;
                                end else begin
                                    unique case (s.btype)
                                        rtc_i2c_pkg::B_SLAVE: n.btype = s.rdPhase ? rtc_i2c_pkg::B_RDATA
                                            : rtc_i2c_pkg::B_AHI;
                                        rtc_i2c_pkg::B_AHI: n.btype = rtc_i2c_pkg::B_ALO;
                                        rtc_i2c_pkg::B_ALO: begin
                                            // Reads use a dummy write then a repeated start
                                            n.btype = s.rd ? rtc_i2c_pkg::B_SLAVE : rtc_i2c_pkg::B_WDATA;
                                            n.rdPhase = s.rd;
                                            n.st = s.rd ? rtc_i2c_pkg::M_START : rtc_i2c_pkg::M_BYTE;
                                        end
                                        default: begin
                                            n.rdData = s.shreg;
                                            n.rdValid = !tx;
                                            n.left = s.left - 5'h01;
                                            // Every transfer ends with a stop
                                            if (s.left <= 5'h01) begin
                                                n.st = rtc_i2c_pkg::M_STOP; // see RQ3, RQ7
                                            end
                                        end
                                    endcase
                                end
                            end
                        end
                    endcase
                end
            end
            default: begin
                // Stop: data rises while the clock is high, sent after release
                if (tick) begin
                    unique case (s.phase)
                        2'h0: begin n.sclLow = 1'b1; n.sdaLow = 1'b1; end
                        2'h1: n.sclLow = 1'b0;
                        2'h2: n.sdaLow = 1'b0; // see RQ3
                        default: n.st = rtc_i2c_pkg::M_IDLE;
                    endcase
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge clock) begin
        if (!nrst) begin
            s <= rtc_i2c_pkg::MASTER_RESET;
        end else begin
            s <= n;
        end
    end

    assign bus.mSclOut = 1'b0;
    assign bus.mSclOe = s.sclLow;
    assign bus.mSdaOut = 1'b0;
    assign bus.mSdaOe = s.sdaLow;
    assign cmdReady = (s.st == rtc_i2c_pkg::M_IDLE);
    assign busy = (s.st != rtc_i2c_pkg::M_IDLE);
    assign rdData = s.rdData;
    assign rdValid = s.rdValid;
    assign nack = s.nack;
endmodule : rtc_i2c_master
`default_nettype wire

/* rtc_i2c_monitor.sv */
// Concurrent checks on the two-wire bus between master and target ends
`timescale 1ns/10ps
`default_nettype none
module rtc_i2c_monitor (
    input wire logic clock, // 200 MHz clock
    input wire logic nrst, // Sync reset, active low
    input wire logic mSclOut, // Master scl value
    input wire logic mSclOe, // Master pulls scl
    input wire logic mSdaOut, // Master sda value
    input wire logic mSdaOe, // Master pulls sda
    input wire logic tSdaOut, // Target sda value
    input wire logic tSdaOe, // Target pulls sda
    input wire logic scl, // Resolved clock line
    input wire logic sda, // Resolved data line
    input wire logic writeBusy // Target write cycle
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);
    logic seenStart;
    logic prevSda;
    // Remember a start on the wires; target activity before one is a fault
    always_ff @(posedge clock) begin
        prevSda <= sda;
        if (!nrst) begin
            seenStart <= 1'b0;
        end else if (scl && prevSda && !sda) begin
            seenStart <= 1'b1;
        end
    end
    sequence s_start;
        scl && $fell(sda);
    endsequence
    sequence s_stop;
        scl && $rose(sda);
    endsequence
    a_tgt_changes_low: assert property ($changed(tSdaOe) |-> !scl)
        else $error("target sda moved, scl high");
    a_no_early_drive: assert property (tSdaOe |-> seenStart) else $error("target drove before start");
    a_start_released: assert property (s_start |-> !tSdaOe) else $error("target held sda at start");
    a_stop_released: assert property (s_stop |-> !tSdaOe) else $error("target held sda at stop");
    a_one_sda_driver: assert property (scl && tSdaOe |-> !mSdaOe) else $error("both ends drive sda");
    // Open drain on both lines: any enabled driver may only pull low
    a_drain_only: assert property ((tSdaOe |-> !tSdaOut) and (mSdaOe |-> !mSdaOut) and (mSclOe |-> !mSclOut))
        else $error("line driven high");
    a_busy_silent: assert property (writeBusy |-> !tSdaOe) else $error("target drove during write cycle");
    a_commit_on_stop: assert property ($rose(writeBusy) |-> scl && sda && !$past(sda, 12))
        else $error("write cycle not started by stop");
endmodule : rtc_i2c_monitor
`default_nettype wire

/* testbench.sv */
// Self-checking bench: master end drives the target end across the carrier
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam int unsigned WriteCycles = 8000; // Longer than one slave byte
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic cmdValid = 1'b0;
    logic cmdRead = 1'b0;
    logic [15:0] cmdAddr = 16'h0000;
    logic [4:0] cmdLen = 5'h01;
    logic [7:0] wrData = 8'h00;
    logic wrValid = 1'b0;
    logic protectArray = 1'b0;
    logic cmdCtl = 1'b0;
    logic cmdReady, wrReady, rdValid, nack, busy, writeBusy;
    logic [7:0] rdData;
    logic [7:0] got;
    int failures = 0;
    int samplesChecked = 0;
    rtc_i2c_if bus ();
    rtc_i2c_master rtc_i2c_master_i (.clock(clock), .nrst(nrst), .bus(bus), .cmdValid(cmdValid),
        .cmdReady(cmdReady), .cmdRead(cmdRead), .cmdCtl(cmdCtl), .cmdAddr(cmdAddr), .cmdLen(cmdLen),
        .wrData(wrData), .wrValid(wrValid), .wrReady(wrReady), .rdData(rdData), .rdValid(rdValid),
        .nack(nack), .busy(busy));
    rtc_i2c_target #(.WriteCycles(WriteCycles)) rtc_i2c_target_i (.clock(clock), .nrst(nrst),
        .bus(bus), .protectArray(protectArray), .writeBusy(writeBusy));
    rtc_i2c_monitor rtc_i2c_monitor_i (.clock(clock), .nrst(nrst), .mSclOut(bus.mSclOut),
        .mSclOe(bus.mSclOe), .mSdaOut(bus.mSdaOut), .mSdaOe(bus.mSdaOe), .tSdaOut(bus.tSdaOut),
        .tSdaOe(bus.tSdaOe), .scl(bus.scl), .sda(bus.sda), .writeBusy(writeBusy));
    always #2.5 clock = ~clock;
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
        samplesChecked++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // One command; the next byte is offered as soon as the current one is taken
    task automatic run_cmd(input logic rd, input logic [15:0] addr, input logic [4:0] len,
            input logic [7:0] d0, input logic [7:0] d1);
        cmdValid <= 1'b1;
        cmdRead <= rd;
        cmdAddr <= addr;
        cmdLen <= len;
        wrData <= d0;
        wrValid <= !rd;
        @(posedge clock);
        cmdValid <= 1'b0;
        do begin
            @(posedge clock);
            if (wrReady === 1'b1) wrData <= d1;
            if (rdValid === 1'b1) got = rdData;
        end while (cmdReady !== 1'b1);
        wrValid <= 1'b0;
    endtask : run_cmd
    // Bounded wait; the caller judges the level reached
    task automatic wait_busy(input logic level, input int limit);
        for (int n = 0; n < limit && writeBusy !== level; n++) begin
            @(posedge clock);
        end
    endtask : wait_busy
    // Two bytes from the last page slot wrap to its first; bus goes deaf meanwhile
    task automatic t_page_wrap();
        run_cmd(1'b0, 16'h001F, 5'h02, 8'hA5, 8'h3C);
        check("write nack", 8'h00, {7'h00, nack});
        wait_busy(1'b1, 200);
        check("busy after stop", 8'h01, {7'h00, writeBusy});
        run_cmd(1'b1, 16'h0010, 5'h01, 8'h00, 8'h00);
        check("nack while busy", 8'h01, {7'h00, nack});
        wait_busy(1'b0, 20000);
        check("busy ended", 8'h00, {7'h00, writeBusy});
    endtask : t_page_wrap
    // Lone day-of-week alarm byte in control space: acked, but no write cycle follows
    task automatic t_dow_single();
        cmdCtl <= 1'b1;
        run_cmd(1'b0, 16'h0006, 5'h01, 8'h5A, 8'h00);
        check("control nack", 8'h00, {7'h00, nack});
        check("master idle", 8'h00, {7'h00, busy});
        wait_busy(1'b1, 200);
        check("dow no cycle", 8'h00, {7'h00, writeBusy});
        cmdCtl <= 1'b0;
    endtask : t_dow_single
    // Protected write is acked, dropped, and starts no cycle
    task automatic t_protect();
        protectArray <= 1'b1;
        run_cmd(1'b0, 16'h0010, 5'h01, 8'h77, 8'h00);
        check("protected nack", 8'h00, {7'h00, nack});
        wait_busy(1'b1, 200);
        check("no write cycle", 8'h00, {7'h00, writeBusy});
        protectArray <= 1'b0;
        run_cmd(1'b1, 16'h0010, 5'h01, 8'h00, 8'h00);
        check("wrapped byte", 8'h3C, got);
        check("read nack", 8'h00, {7'h00, nack});
    endtask : t_protect
    task automatic end_of_test();
        $display("failures %0d checks %0d", failures, samplesChecked);
        if (failures == 0 && samplesChecked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        t_page_wrap();
        t_dow_single();
        t_protect();
        end_of_test();
    end
    // Watchdog: the sequence needs about 94k cycles, so a hang ends near 100k
    initial begin
        #500000;
        failures++;
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
